//--- verilog/upss_pkg.sv
// Shared constants for the status signaling block
package upss_pkg;
  // ---------------------------------------------------------------
  // Clock and flash timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned SVC_FLASH_HZ    = 2;
  localparam int unsigned SVC_HALF_CYC    = CLK_HZ / (SVC_FLASH_HZ * 2);
  localparam int unsigned FAST_FLASH_HZ   = 4;
  localparam int unsigned FAST_HALF_CYC   = CLK_HZ / (FAST_FLASH_HZ * 2);
  // Charge-level burst: pulse half-period and pause in half-periods of the 2 Hz flash
  localparam int unsigned BURST_PAUSE_HP  = 6;
  // Charge-level bands
  localparam logic [6:0]  LEVEL_FULL      = 7'h64;
  localparam logic [6:0]  BAND_WIDTH      = 7'h14;
  localparam int unsigned MAX_PULSES      = 5;
  // Number of signal outputs
  localparam int unsigned NUM_SIG         = 6;
  localparam int unsigned SIG_ALARM       = 0;
  localparam int unsigned SIG_BATT_MODE   = 1;
  localparam int unsigned SIG_LOAD_OK     = 2;
  localparam int unsigned SIG_FULL        = 3;
  localparam int unsigned SIG_OVERPOWER   = 4;
  localparam int unsigned SIG_SERVICE     = 5;
  // Reset value of the inversion setting (none inverted)
  localparam logic [5:0]  INVERT_RESET    = 6'h00;
  // Indicator patterns
  typedef enum logic [1:0] {
    UPSS_OFF  = 2'b00,
    UPSS_ON   = 2'b01,
    UPSS_SLOW = 2'b10,
    UPSS_FAST = 2'b11
  } upss_pat_t;
endpackage

//--- verilog/upss_flash.sv
// Flash-rate divider and charge-level burst generator
`timescale 1ns/1ps
module upss_flash #(
  parameter int unsigned SLOW_HALF = upss_pkg::SVC_HALF_CYC,
  parameter int unsigned FAST_HALF = upss_pkg::FAST_HALF_CYC
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Charge level, percent
  input  wire logic [6:0] charge_level,
  // Phases
  output logic            slow_phase,
  output logic            fast_phase,
  output logic            burst_phase
);
  // ---------------------------------------------------------------
  // Dividers
  // ---------------------------------------------------------------
  logic [31:0] slow_cnt_ff;
  logic [31:0] fast_cnt_ff;
  logic        slow_tick;
  logic        fast_tick;
  logic        slow_ff;
  logic        fast_ff;
  assign slow_tick = (slow_cnt_ff == SLOW_HALF - 1);
  assign fast_tick = (fast_cnt_ff == FAST_HALF - 1);
  always_ff @(posedge clock) begin
    if (rst) begin
      slow_cnt_ff <= 32'h0;
      fast_cnt_ff <= 32'h0;
      slow_ff     <= 1'b0;
      fast_ff     <= 1'b0;
    end else begin
      slow_cnt_ff <= slow_tick ? 32'h0 : slow_cnt_ff + 32'h1;
      fast_cnt_ff <= fast_tick ? 32'h0 : fast_cnt_ff + 32'h1;
      if (slow_tick) begin
        slow_ff <= ~slow_ff;
      end
      if (fast_tick) begin
        fast_ff <= ~fast_ff;
      end
    end
  end
  assign slow_phase = slow_ff;
  assign fast_phase = fast_ff;

  // ---------------------------------------------------------------
  // Burst: N pulses then a long pause
  // ---------------------------------------------------------------
  // Pulse count latched at burst start so a level change never cuts a burst short
  logic [2:0] pulses;
  logic [2:0] target_ff;
  logic [3:0] hp_ff;
  logic       burst_ff;
  logic [4:0] burst_len;
  assign pulses = (charge_level == 7'h00)           ? 3'h0 :
                  (charge_level <= 7'h14)           ? 3'h1 :
                  (charge_level <= 7'h28)           ? 3'h2 :
                  (charge_level <= 7'h3C)           ? 3'h3 :
                  (charge_level <= 7'h50)           ? 3'h4 : 3'h5;
  // Five pulses plus the pause need sixteen half-periods, one bit more than the count
  assign burst_len = {1'b0, target_ff, 1'b0} + 5'(upss_pkg::BURST_PAUSE_HP);
  always_ff @(posedge clock) begin
    if (rst) begin
      hp_ff     <= 4'h0;
      target_ff <= 3'h0;
      burst_ff  <= 1'b0;
    end else if (slow_tick) begin
      if ({1'b0, hp_ff} >= burst_len - 5'h01) begin
        hp_ff     <= 4'h0;
        target_ff <= pulses;
        burst_ff  <= (pulses != 3'h0);
      end else begin
        hp_ff    <= hp_ff + 4'h1;
        // Lit on even half-periods only, so pulses and gaps are equal
        burst_ff <= (hp_ff + 4'h1 < {target_ff, 1'b0}) && hp_ff[0];
      end
    end
  end
  assign burst_phase = burst_ff;
endmodule

//--- verilog/upss_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module upss_sync #(
  parameter int unsigned WIDTH = 3
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Asynchronous in, synchronised out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end
  assign sync_out = sync_ff;
endmodule

//--- verilog/upss_top.sv
// UPS status signaling: indicator LEDs and signal outputs
`timescale 1ns/1ps
module upss_top #(
  parameter int unsigned SLOW_HALF = upss_pkg::SVC_HALF_CYC,
  parameter int unsigned FAST_HALF = upss_pkg::FAST_HALF_CYC,
  parameter int unsigned CFG_W     = 4
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Power stage status
  input  wire logic             input_valid,
  input  wire logic             bypass_active,
  input  wire logic             bypass_fuse_bad,
  input  wire logic             parallel_active,
  input  wire logic             parallel_disrupted,
  input  wire logic             output_valid,
  input  wire logic             inverter_active,
  input  wire logic             overload,
  input  wire logic             protective_bypass,
  input  wire logic             battery_present,
  input  wire logic             battery_error,
  input  wire logic             on_battery,
  input  wire logic             rectifier_active,
  input  wire logic             overpower,
  input  wire logic             fan_replace,
  input  wire logic             battery_replace,
  input  wire logic [6:0]       charge_level,
  // Fault groups
  input  wire logic [6:0]       general_faults,
  input  wire logic [8:0]       battery_faults,
  input  wire logic [2:0]       parallel_faults,
  // Pins: service button, remote, battery start
  input  wire logic             service_button,
  input  wire logic             remote_in,
  input  wire logic             bat_start_in,
  // Configuration
  input  wire logic [5:0]       sig_invert,
  input  wire logic [CFG_W-1:0] remote_cfg,
  // Indicator LEDs
  output logic                  led_input,
  output logic                  led_bypass,
  output logic                  led_parallel,
  output logic                  led_output,
  output logic                  led_inverter,
  output logic                  led_alarm,
  output logic                  led_battery,
  output logic                  led_service,
  output logic                  led_storage,
  output logic                  led_rectifier,
  // Signal outputs
  output logic                  alarm_output_n,
  output logic                  battery_mode_output,
  output logic                  load_supplied_output,
  output logic                  storage_full_output,
  output logic                  overpower_output,
  output logic                  maintenance_output,
  // Status
  output logic                  service_mode,
  output logic                  remote_active,
  output logic                  bat_start,
  output logic [CFG_W-1:0]      remote_cfg_applied
);
  // ---------------------------------------------------------------
  // Pin synchronisation and flash phases
  // ---------------------------------------------------------------
  logic [2:0] pins_sync;
  logic       slow_phase;
  logic       fast_phase;
  logic       burst_phase;
  upss_sync #(.WIDTH(3)) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({bat_start_in, remote_in, service_button}),
    .sync_out (pins_sync)
  );
  upss_flash #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) u_flash (
    .clock        (clock),
    .rst          (rst),
    .charge_level (charge_level),
    .slow_phase   (slow_phase),
    .fast_phase   (fast_phase),
    .burst_phase  (burst_phase)
  );

  // ---------------------------------------------------------------
  // Service mode and remote configuration
  // ---------------------------------------------------------------
  logic             btn_prev_ff;
  logic             rem_prev_ff;
  logic             svc_ff;
  logic [CFG_W-1:0] rcfg_ff;
  logic             remote_active_ff;
  logic             btn_press;
  logic             rem_change;
  logic             first_ff;
  assign btn_press  = pins_sync[0] & ~btn_prev_ff;
  assign rem_change = pins_sync[1] ^ rem_prev_ff;
  always_ff @(posedge clock) begin
    if (rst) begin
      btn_prev_ff <= 1'b0;
      rem_prev_ff <= 1'b0;
      svc_ff      <= 1'b0;
      rcfg_ff     <= '0;
      first_ff    <= 1'b1;
    end else begin
      btn_prev_ff <= pins_sync[0];
      rem_prev_ff <= pins_sync[1];
      first_ff    <= 1'b0;
      if (btn_press) begin
        svc_ff <= ~svc_ff;
      end
      // Restart counts as an apply point; otherwise only a remote change
      if (first_ff | rem_change) begin
        rcfg_ff <= remote_cfg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Conditions
  // ---------------------------------------------------------------
  logic alarm_any;
  logic full;
  assign alarm_any = (|general_faults) | svc_ff | (|battery_faults) | (|parallel_faults);
  assign full      = (charge_level >= upss_pkg::LEVEL_FULL);

  // ---------------------------------------------------------------
  // LED pattern selection
  // ---------------------------------------------------------------
  upss_pkg::upss_pat_t p_bypass;
  upss_pkg::upss_pat_t p_parallel;
  upss_pkg::upss_pat_t p_output;
  upss_pkg::upss_pat_t p_inverter;
  upss_pkg::upss_pat_t p_alarm;
  upss_pkg::upss_pat_t p_service;
  upss_pkg::upss_pat_t p_storage;
  upss_pkg::upss_pat_t p_rectifier;
  assign p_bypass    = bypass_fuse_bad    ? upss_pkg::UPSS_SLOW :
                       bypass_active      ? upss_pkg::UPSS_ON   : upss_pkg::UPSS_OFF;
  assign p_parallel  = parallel_disrupted ? upss_pkg::UPSS_SLOW :
                       parallel_active    ? upss_pkg::UPSS_ON   : upss_pkg::UPSS_OFF;
  assign p_output    = ~output_valid      ? upss_pkg::UPSS_OFF  :
                       remote_active_ff   ? upss_pkg::UPSS_SLOW : upss_pkg::UPSS_ON;
  assign p_inverter  = protective_bypass  ? upss_pkg::UPSS_FAST :
                       overload           ? upss_pkg::UPSS_SLOW :
                       inverter_active    ? upss_pkg::UPSS_ON   : upss_pkg::UPSS_OFF;
  assign p_alarm     = alarm_any & ~svc_ff ? upss_pkg::UPSS_ON :
                       svc_ff             ? upss_pkg::UPSS_SLOW : upss_pkg::UPSS_OFF;
  assign p_service   = fan_replace        ? upss_pkg::UPSS_ON   :
                       battery_replace    ? upss_pkg::UPSS_SLOW : upss_pkg::UPSS_OFF;
  assign p_storage   = on_battery         ? upss_pkg::UPSS_ON   :
                       ~full              ? upss_pkg::UPSS_SLOW : upss_pkg::UPSS_OFF;
  assign p_rectifier = protective_bypass  ? upss_pkg::UPSS_FAST :
                       overload           ? upss_pkg::UPSS_SLOW :
                       rectifier_active   ? upss_pkg::UPSS_ON   : upss_pkg::UPSS_OFF;

  function automatic logic upss_drive(input upss_pkg::upss_pat_t p, input logic slow, input logic fast);
    case (p)
      upss_pkg::UPSS_ON:   upss_drive = 1'b1;
      upss_pkg::UPSS_SLOW: upss_drive = slow;
      upss_pkg::UPSS_FAST: upss_drive = fast;
      default:             upss_drive = 1'b0;
    endcase
  endfunction

  // Battery LED: error flashes plainly, charge shown as bursts, full steady
  logic nxt_led_battery;
  assign nxt_led_battery = ~battery_present ? 1'b0 :
                           battery_error    ? slow_phase :
                           full             ? 1'b1 : burst_phase;

  // ---------------------------------------------------------------
  // Signal outputs: condition then per-output inversion
  // ---------------------------------------------------------------
  logic [5:0] sig_cond;
  logic [5:0] nxt_sig;
  assign sig_cond[upss_pkg::SIG_ALARM]     = ~alarm_any;
  assign sig_cond[upss_pkg::SIG_BATT_MODE] = on_battery;
  assign sig_cond[upss_pkg::SIG_LOAD_OK]   = output_valid;
  assign sig_cond[upss_pkg::SIG_FULL]      = full;
  assign sig_cond[upss_pkg::SIG_OVERPOWER] = overpower;
  assign sig_cond[upss_pkg::SIG_SERVICE]   = fan_replace | battery_replace;
  assign nxt_sig = sig_cond ^ sig_invert;

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  logic [9:0] led_ff;
  logic [5:0] sig_ff;
  logic       bat_start_ff;
  always_ff @(posedge clock) begin
    if (rst) begin
      led_ff           <= 10'h000;
      sig_ff           <= upss_pkg::INVERT_RESET ^ 6'h01;
      remote_active_ff <= 1'b0;
      bat_start_ff     <= 1'b0;
    end else begin
      led_ff[0] <= input_valid;
      led_ff[1] <= upss_drive(p_bypass, slow_phase, fast_phase);
      led_ff[2] <= upss_drive(p_parallel, slow_phase, fast_phase);
      led_ff[3] <= upss_drive(p_output, slow_phase, fast_phase);
      led_ff[4] <= upss_drive(p_inverter, slow_phase, fast_phase);
      led_ff[5] <= upss_drive(p_alarm, slow_phase, fast_phase);
      led_ff[6] <= nxt_led_battery;
      led_ff[7] <= upss_drive(p_service, slow_phase, fast_phase);
      led_ff[8] <= upss_drive(p_storage, slow_phase, fast_phase);
      led_ff[9] <= upss_drive(p_rectifier, slow_phase, fast_phase);
      sig_ff           <= nxt_sig;
      remote_active_ff <= pins_sync[1];
      bat_start_ff     <= pins_sync[2];
    end
  end
  assign led_input            = led_ff[0];
  assign led_bypass           = led_ff[1];
  assign led_parallel         = led_ff[2];
  assign led_output           = led_ff[3];
  assign led_inverter         = led_ff[4];
  assign led_alarm            = led_ff[5];
  assign led_battery          = led_ff[6];
  assign led_service          = led_ff[7];
  assign led_storage          = led_ff[8];
  assign led_rectifier        = led_ff[9];
  assign alarm_output_n       = sig_ff[upss_pkg::SIG_ALARM];
  assign battery_mode_output  = sig_ff[upss_pkg::SIG_BATT_MODE];
  assign load_supplied_output = sig_ff[upss_pkg::SIG_LOAD_OK];
  assign storage_full_output  = sig_ff[upss_pkg::SIG_FULL];
  assign overpower_output     = sig_ff[upss_pkg::SIG_OVERPOWER];
  assign maintenance_output   = sig_ff[upss_pkg::SIG_SERVICE];
  assign service_mode         = svc_ff;
  assign remote_active        = remote_active_ff;
  assign bat_start            = bat_start_ff;
  assign remote_cfg_applied   = rcfg_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_INPUT_LED: assert property (@(posedge clock) disable iff (rst)
    input_valid |=> led_input) else $error("input led not lit");
  AST_SVC_TOGGLE: assert property (@(posedge clock) disable iff (rst)
    btn_press |=> (svc_ff != $past(svc_ff))) else $error("service mode did not toggle");
  AST_ALARM_PIN: assert property (@(posedge clock) disable iff (rst)
    (alarm_any && !sig_invert[0]) |=> !alarm_output_n) else $error("alarm pin not low");
  AST_INVERT: assert property (@(posedge clock) disable iff (rst)
    (overpower && sig_invert[4]) |=> !overpower_output) else $error("inversion not applied");
  AST_FULL_OUT: assert property (@(posedge clock) disable iff (rst)
    (charge_level < 7'h64 && !sig_invert[3]) |=> !storage_full_output) else $error("full out early");
  AST_BATT_MODE: assert property (@(posedge clock) disable iff (rst)
    (on_battery && !sig_invert[1]) |=> battery_mode_output) else $error("battery mode low");
  AST_REMOTE_HOLD: assert property (@(posedge clock) disable iff (rst)
    (!rem_change && !first_ff) |=> $stable(rcfg_ff)) else $error("remote cfg applied early");
  AST_SVC_FLASH: assert property (@(posedge clock) disable iff (rst)
    (svc_ff && $past(svc_ff)) |=> (led_alarm == $past(slow_phase))) else $error("alarm led not flashing");
  AST_MAINT: assert property (@(posedge clock) disable iff (rst)
    (fan_replace && !sig_invert[5]) |=> ##0 maintenance_output) else $error("maintenance low");
  AST_INPUT_DARK: assert property (@(posedge clock) disable iff (rst)
    !input_valid |=> !led_input) else $error("input led lit without valid input");
  AST_BYPASS_FLASH: assert property (@(posedge clock) disable iff (rst)
    bypass_fuse_bad |=> (led_bypass == $past(slow_phase))) else $error("bypass led not flashing");
  AST_PAR_FLASH: assert property (@(posedge clock) disable iff (rst)
    parallel_disrupted |=> (led_parallel == $past(slow_phase))) else $error("parallel led not flashing");
  AST_PROT_FAST: assert property (@(posedge clock) disable iff (rst)
    protective_bypass |=> (led_inverter == $past(fast_phase)) && (led_rectifier == $past(fast_phase)))
    else $error("protective bypass leds not fast together");
  AST_ALARM_LED: assert property (@(posedge clock) disable iff (rst)
    (alarm_any && !svc_ff) |=> led_alarm) else $error("alarm led not steady");
  AST_GEN_FAULT: assert property (@(posedge clock) disable iff (rst)
    ((|general_faults) && !sig_invert[0]) |=> !alarm_output_n) else $error("general fault not raised");
  AST_BATT_FAULT: assert property (@(posedge clock) disable iff (rst)
    ((|battery_faults) && !sig_invert[0]) |=> !alarm_output_n) else $error("battery fault not raised");
  AST_PAR_FAULT: assert property (@(posedge clock) disable iff (rst)
    ((|parallel_faults) && !sig_invert[0]) |=> !alarm_output_n) else $error("parallel fault not raised");
  AST_LOAD_OUT: assert property (@(posedge clock) disable iff (rst)
    (output_valid && !sig_invert[2]) |=> load_supplied_output) else $error("load supplied low");
  AST_OVERPOWER_OUT: assert property (@(posedge clock) disable iff (rst)
    (overpower && !sig_invert[4]) |=> overpower_output) else $error("overpower output low");
endmodule

//--- test/upss_ctrl_model.sv
// Model of the control system that reads the six signal outputs
`timescale 1ns/1ps
module upss_ctrl_model (
  // Signal output pins
  input  wire logic       alarm_output_n,
  input  wire logic       battery_mode_output,
  input  wire logic       load_supplied_output,
  input  wire logic       storage_full_output,
  input  wire logic       overpower_output,
  input  wire logic       maintenance_output,
  // Inversion setting known to the control system
  input  wire logic [5:0] sig_invert,
  // Decoded conditions, high = active
  output logic [5:0]      cond
);
  // ---------------------------------------------------------------
  // Pin decoding
  // ---------------------------------------------------------------
  // The reader must undo each inversion, else a flipped pin reads as a fault
  assign cond[0] = ~alarm_output_n ^ sig_invert[0];
  assign cond[1] = battery_mode_output ^ sig_invert[1];
  assign cond[2] = load_supplied_output ^ sig_invert[2];
  assign cond[3] = storage_full_output ^ sig_invert[3];
  assign cond[4] = overpower_output ^ sig_invert[4];
  assign cond[5] = maintenance_output ^ sig_invert[5];
endmodule

//--- test/tb_upss_top.sv
// Self-checking testbench for the status signaling block
`timescale 1ns/1ps
module tb_upss_top;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  // Short flash periods keep the run brief
  localparam int unsigned SH = 4;
  localparam upss_pkg::upss_pat_t OFF = upss_pkg::UPSS_OFF;
  localparam upss_pkg::upss_pat_t ON = upss_pkg::UPSS_ON;
  localparam upss_pkg::upss_pat_t SL = upss_pkg::UPSS_SLOW;
  localparam upss_pkg::upss_pat_t FA = upss_pkg::UPSS_FAST;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] st = 16'h0000;
  logic [18:0] flt = 19'h00000;
  logic [6:0]  lvl = 7'h00;
  logic        service_button = 1'b0;
  logic        remote_in = 1'b0;
  logic        bat_start_in = 1'b0;
  logic [5:0]  sig_invert = 6'h00;
  logic [3:0]  remote_cfg = 4'hA;
  logic [9:0]  leds;
  logic [5:0]  so;
  logic [5:0]  cond;
  logic        service_mode;
  logic [3:0]  cfg_applied;
  logic        remote_active;
  logic        bat_start;
  // Band edges of the charge display
  logic [6:0]  lvl_tab [10] = '{7'h01, 7'h14, 7'h15, 7'h28, 7'h29, 7'h3C, 7'h3D, 7'h50, 7'h51, 7'h63};
  logic        svc = 1'b0;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          seed = 32'hcac6;
  int          m_hi;
  int          m_rs;

  always #5 clock = ~clock;

  upss_top #(.SLOW_HALF(SH), .FAST_HALF(2), .CFG_W(4)) uut (
    .clock(clock), .rst(rst),
    .input_valid(st[0]), .bypass_active(st[1]), .bypass_fuse_bad(st[2]), .parallel_active(st[3]),
    .parallel_disrupted(st[4]), .output_valid(st[5]), .inverter_active(st[6]), .overload(st[7]),
    .protective_bypass(st[8]), .battery_present(st[9]), .battery_error(st[10]), .on_battery(st[11]),
    .rectifier_active(st[12]), .overpower(st[13]), .fan_replace(st[14]), .battery_replace(st[15]),
    .charge_level(lvl), .general_faults(flt[6:0]), .battery_faults(flt[15:7]), .parallel_faults(flt[18:16]),
    .service_button(service_button), .remote_in(remote_in), .bat_start_in(bat_start_in),
    .sig_invert(sig_invert), .remote_cfg(remote_cfg),
    .led_input(leds[0]), .led_bypass(leds[1]), .led_parallel(leds[2]), .led_output(leds[3]),
    .led_inverter(leds[4]), .led_alarm(leds[5]), .led_battery(leds[6]), .led_service(leds[7]),
    .led_storage(leds[8]), .led_rectifier(leds[9]),
    .alarm_output_n(so[0]), .battery_mode_output(so[1]), .load_supplied_output(so[2]),
    .storage_full_output(so[3]), .overpower_output(so[4]), .maintenance_output(so[5]),
    .service_mode(service_mode), .remote_active(remote_active), .bat_start(bat_start),
    .remote_cfg_applied(cfg_applied)
  );

  upss_ctrl_model ctrl (
    .alarm_output_n(so[0]), .battery_mode_output(so[1]), .load_supplied_output(so[2]),
    .storage_full_output(so[3]), .overpower_output(so[4]), .maintenance_output(so[5]),
    .sig_invert(sig_invert), .cond(cond)
  );

  // ---------------------------------------------------------------
  // Expectations and compares
  // ---------------------------------------------------------------
  function automatic logic [5:0] exp_cond(input logic [15:0] s, input logic [18:0] f,
                                          input logic [6:0] l, input logic m);
    exp_cond[0] = (|f) | m;
    exp_cond[1] = s[11];
    exp_cond[2] = s[5];
    exp_cond[3] = (l == 7'h64);
    exp_cond[4] = s[13];
    exp_cond[5] = s[14] | s[15];
  endfunction

  task automatic summarize();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check_vec(input string nm, input logic [5:0] e, input logic [5:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_int(input string nm, input int e, input int g);
    n_compared++;
    if (g != e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic check_pat(input string nm, input upss_pkg::upss_pat_t e, input upss_pkg::upss_pat_t g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %s seen %s", nm, e.name(), g.name());
    end
  endtask

  // Watch one LED for 64 cycles: lit cycles and rising edges
  task automatic meas(input int i);
    logic p;
    m_hi = 0;
    m_rs = 0;
    p = leds[i];
    repeat (64) begin
      @(posedge clock);
      #1;
      m_hi += (leds[i] === 1'b1) ? 1 : 0;
      m_rs += (leds[i] === 1'b1 && p !== 1'b1) ? 1 : 0;
      p = leds[i];
    end
  endtask

  function automatic upss_pkg::upss_pat_t pclass();
    if (m_hi == 0) return OFF;
    if (m_hi == 64) return ON;
    return (m_rs >= 12) ? FA : SL;
  endfunction

  task automatic led_case(input int i, input logic [15:0] s, input logic [18:0] f, input logic [6:0] l,
                          input logic r, input upss_pkg::upss_pat_t e);
    @(posedge clock);
    st <= s;
    flt <= f;
    lvl <= l;
    remote_in <= r;
    repeat (8) @(posedge clock);
    meas(i);
    check_pat($sformatf("led %0d", i), e, pclass());
    check_vec("signal outputs", exp_cond(st, flt, lvl, svc), cond);
  endtask

  task automatic press();
    @(posedge clock);
    service_button <= 1'b1;
    repeat (4) @(posedge clock);
    service_button <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
    svc = ~svc;
    check_vec("service mode", 6'(svc), 6'(service_mode));
  endtask

  // Sync on the long dark pause, then count pulses up to the next pause
  task automatic burst(input logic [6:0] l);
    int run;
    int n;
    int t;
    logic p;
    @(posedge clock);
    lvl <= l;
    st <= 16'h0200;
    run = 0;
    n = 0;
    t = 0;
    p = 1'b0;
    while ((run <= 2 * SH || t < 80) && t < 300) begin
      @(posedge clock);
      #1;
      run = (leds[6] === 1'b0) ? run + 1 : 0;
      t++;
    end
    while ((n == 0 || run <= 2 * SH) && t < 600) begin
      @(posedge clock);
      #1;
      n += (leds[6] === 1'b1 && p !== 1'b1) ? 1 : 0;
      run = (leds[6] === 1'b0) ? run + 1 : 0;
      p = leds[6];
      t++;
    end
    if (t >= 600) begin
      n_mismatch++;
      summarize();
    end
    check_int("pulse count", (int'(l) + 19) / 20, n);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    check_vec("cfg after restart", 6'(4'hA), 6'(cfg_applied));
    for (int k = 0; k < 80; k++) begin
      @(posedge clock);
      st <= (16'($random(seed)) & 16'hFA7F) | 16'h0200;
      flt <= ((k % 3) == 0) ? 19'($random(seed)) : 19'h00000;
      lvl <= ((k % 4) == 0) ? 7'h64 : 7'(($random(seed) & 32'h7FFF) % 101);
      sig_invert <= 6'($random(seed));
      bat_start_in <= 1'($random(seed));
      @(posedge clock);
      #1;
      check_vec("signal outputs", exp_cond(st, flt, lvl, svc), cond);
    end
    @(posedge clock);
    remote_cfg <= 4'h5;
    repeat (10) @(posedge clock);
    #1;
    check_vec("cfg held", 6'(4'hA), 6'(cfg_applied));
    @(posedge clock);
    remote_in <= 1'b1;
    repeat (6) @(posedge clock);
    #1;
    check_vec("cfg applied", 6'(4'h5), 6'(cfg_applied));
    check_vec("pin status", {4'h0, bat_start_in, 1'b1}, {4'h0, bat_start, remote_active});
    for (int i = 0; i < 10; i++) begin
      led_case(i, 16'h0000, 19'h0, 7'h64, 1'b0, OFF);
    end
    led_case(7, 16'h4000, 19'h0, 7'h00, 1'b0, ON);
    led_case(7, 16'h8000, 19'h0, 7'h00, 1'b0, SL);
    led_case(0, 16'h0001, 19'h0, 7'h00, 1'b0, ON);
    led_case(1, 16'h0002, 19'h0, 7'h00, 1'b0, ON);
    led_case(1, 16'h0004, 19'h0, 7'h00, 1'b0, SL);
    led_case(2, 16'h0008, 19'h0, 7'h00, 1'b0, ON);
    led_case(2, 16'h0010, 19'h0, 7'h00, 1'b0, SL);
    led_case(3, 16'h0020, 19'h0, 7'h00, 1'b0, ON);
    led_case(3, 16'h0020, 19'h0, 7'h00, 1'b1, SL);
    led_case(4, 16'h0040, 19'h0, 7'h00, 1'b0, ON);
    led_case(4, 16'h00C0, 19'h0, 7'h00, 1'b0, SL);
    led_case(4, 16'h1140, 19'h0, 7'h00, 1'b0, FA);
    led_case(9, 16'h1140, 19'h0, 7'h00, 1'b0, FA);
    led_case(5, 16'h0000, 19'h4, 7'h00, 1'b0, ON);
    led_case(6, 16'h0200, 19'h0, 7'h64, 1'b0, ON);
    led_case(6, 16'h0600, 19'h0, 7'h32, 1'b0, SL);
    led_case(8, 16'h0800, 19'h0, 7'h32, 1'b0, ON);
    led_case(8, 16'h0200, 19'h0, 7'h32, 1'b0, SL);
    led_case(8, 16'h0200, 19'h0, 7'h64, 1'b0, OFF);
    led_case(9, 16'h1000, 19'h0, 7'h00, 1'b0, ON);
    led_case(9, 16'h1080, 19'h0, 7'h00, 1'b0, SL);
    press();
    led_case(5, 16'h0000, 19'h0, 7'h00, 1'b0, SL);
    check_int("service flash lit cycles", 32, m_hi);
    press();
    foreach (lvl_tab[j]) burst(lvl_tab[j]);
    summarize();
  end
endmodule
